/* File: design/lt_err_consts.vh */
// Offsets, field positions, reset values and codes for the error block
`ifndef LT_ERR_CONSTS_VH
`define LT_ERR_CONSTS_VH

// Register byte offsets
`define HDR_OFS            16'h1000
`define FLAGS_OFS          16'h1008
`define ENABLES_OFS        16'h100C

// Header contents: pointer in the upper halfword, feature id in the lower
`define NEXT_PTR_VAL       16'h0000
`define FEATURE_ID_VAL     16'h0007

// Flag and enable positions (printed bit n = vector bit 31-n)
`define ILL_REQ_BIT        5'h1B
`define ILL_RESP_BIT       5'h17
`define UNSUP_PW_BIT       5'h16

// Reset values
`define FLAGS_RST          3'h0
`define ENABLES_RST        3'h0

// Packet field codes
`define FTYPE_MAINT        4'h8
`define TTYPE_RD_REQ       4'h0
`define TTYPE_WR_REQ       4'h1
`define TTYPE_RD_RESP      4'h2
`define TTYPE_WR_RESP      4'h3
`define TTYPE_PORT_WRITE   4'h4
`define TTYPE_ILL_LO       4'h5
`define TT_ILL_A           2'h2
`define TT_ILL_B           2'h3
`define HOP_TERMINATE      8'h00

// Bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* File: design/maint_classify.v */
// Classifies incoming maintenance packet headers into error events
`include "lt_err_consts.vh"

module maint_classify (
    // Clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // Packet header strobe
    input  wire       pkt_valid,
    input  wire [3:0] pkt_ftype,
    input  wire [3:0] pkt_ttype,
    input  wire [1:0] pkt_tt,
    input  wire [7:0] pkt_hop,
    // Registered error events, one-cycle pulses
    output reg        ill_req_r,
    output reg        ill_resp_r,
    output reg        unsup_pw_r
);

    wire terminating;
    wire is_request;
    wire tt_bad;

    // Only hop-count-zero maintenance reaches this layer
    assign terminating = pkt_valid && (pkt_ftype == `FTYPE_MAINT) &&
                         (pkt_hop == `HOP_TERMINATE);
    assign is_request  = (pkt_ttype == `TTYPE_RD_REQ) ||
                         (pkt_ttype == `TTYPE_WR_REQ);
    assign tt_bad      = (pkt_tt == `TT_ILL_A) || (pkt_tt == `TT_ILL_B);

    always @(posedge aclk) begin
        if (!aresetn) begin
            ill_req_r  <= 1'b0;
            ill_resp_r <= 1'b0;
            unsup_pw_r <= 1'b0;
        end else begin
            // Reserved ttype, or a request with bad transport code
            ill_req_r  <= terminating &&
                          ((pkt_ttype >= `TTYPE_ILL_LO) ||
                           (is_request && tt_bad));
            // Responses are never legal at hop zero
            ill_resp_r <= terminating &&
                          ((pkt_ttype == `TTYPE_RD_RESP) ||
                           (pkt_ttype == `TTYPE_WR_RESP));
            // Port-writes at hop zero are unsupported
            unsup_pw_r <= terminating &&
                          (pkt_ttype == `TTYPE_PORT_WRITE);
        end
    end

endmodule // maint_classify

/* File: design/logical_transport_error_detect.v */
// Logical/transport error detect, enable and header registers on AXI4-Lite
//
// Operation
// - The header's upper halfword is a fixed zero next-block pointer.
// - The header's lower halfword is the fixed feature id seven.
// - Hop-zero requests with bad ttype or transport code set bit 4.
// - Hop-zero maintenance responses set bit 8.
// - Hop-zero port-writes set bit 9.
// - Errors seen in one cycle set all their flags together.
// - Only hop-zero maintenance packets can raise these flags.
// - An enable decides whether its error locks and is reported.
// - Enables at bits 4, 8 and 9 are read-write, one on, reset zero.
// - Capture freezes on an enabled error, not on ordinary failures.
// - Hard reset restores all reset values; device self-reset restores only flags, enables, lock and capture.
//
// Local design decision: register access over AXI4-Lite.
`include "lt_err_consts.vh"

module logical_transport_error_detect #(
    parameter ADDR_W = 16
) (
    // Clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    input  wire              self_reset,
    // AXI4-Lite write address
    input  wire [ADDR_W-1:0] awaddr,
    input  wire [2:0]        awprot,
    input  wire              awvalid,
    output reg               awready,
    // AXI4-Lite write data
    input  wire [31:0]       wdata,
    input  wire [3:0]        wstrb,
    input  wire              wvalid,
    output reg               wready,
    // AXI4-Lite write response
    output reg  [1:0]        bresp,
    output reg               bvalid,
    input  wire              bready,
    // AXI4-Lite read address
    input  wire [ADDR_W-1:0] araddr,
    input  wire [2:0]        arprot,
    input  wire              arvalid,
    output reg               arready,
    // AXI4-Lite read data
    output reg  [31:0]       rdata,
    output reg  [1:0]        rresp,
    output reg               rvalid,
    input  wire              rready,
    // Packet header strobe from the logical layer
    input  wire              pkt_valid,
    input  wire [3:0]        pkt_ftype,
    input  wire [3:0]        pkt_ttype,
    input  wire [1:0]        pkt_tt,
    input  wire [7:0]        pkt_hop,
    // Lock and report towards capture and reporting logic
    output reg               capture_load_r,
    output reg               err_locked_r
);

    localparam SEL_NONE  = 2'h0;
    localparam SEL_HDR   = 2'h1;
    localparam SEL_FLAGS = 2'h2;
    localparam SEL_EN    = 2'h3;
    localparam NFIELD    = 3;

    // Address decode shared by the read and write paths
    function [1:0] reg_sel;
        input [ADDR_W-1:0] addr;
        reg   [15:0]       word;
        begin
            word = {addr[15:2], 2'b00};
            if (word == `HDR_OFS) begin
                reg_sel = SEL_HDR;
            end else if (word == `FLAGS_OFS) begin
                reg_sel = SEL_FLAGS;
            end else if (word == `ENABLES_OFS) begin
                reg_sel = SEL_EN;
            end else begin
                reg_sel = SEL_NONE;
            end
        end
    endfunction

    // Expand a three-bit field set into its word positions
    function [31:0] place3;
        input [2:0] v;
        begin
            place3                = 32'h00000000;
            place3[`ILL_REQ_BIT]  = v[0];
            place3[`ILL_RESP_BIT] = v[1];
            place3[`UNSUP_PW_BIT] = v[2];
        end
    endfunction

    // Byte lane strobe that covers a given word bit
    function lane_on;
        input [3:0] strb;
        input [4:0] bitpos;
        begin
            lane_on = strb[bitpos[4:3]];
        end
    endfunction

    // Word position of field idx: request, response, port-write
    function [4:0] field_pos;
        input integer idx;
        begin
            if (idx == 0) begin
                field_pos = `ILL_REQ_BIT;
            end else if (idx == 1) begin
                field_pos = `ILL_RESP_BIT;
            end else begin
                field_pos = `UNSUP_PW_BIT;
            end
        end
    endfunction

    // Pulses from the packet classifier
    wire ill_req_ev;
    wire ill_resp_ev;
    wire unsup_pw_ev;

    maint_classify u_classify (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pkt_valid  (pkt_valid),
        .pkt_ftype  (pkt_ftype),
        .pkt_ttype  (pkt_ttype),
        .pkt_tt     (pkt_tt),
        .pkt_hop    (pkt_hop),
        .ill_req_r  (ill_req_ev),
        .ill_resp_r (ill_resp_ev),
        .unsup_pw_r (unsup_pw_ev)
    );

    // Write channel holding registers
    reg  [ADDR_W-1:0] awaddr_r;
    reg               aw_held_r;
    reg  [31:0]       wdata_r;
    reg  [3:0]        wstrb_r;
    reg               w_held_r;

    // Block state
    reg  [2:0]        flags_r;
    reg  [2:0]        flags_nxt;
    reg  [2:0]        enables_r;
    reg  [2:0]        enables_nxt;

    wire              do_write;
    wire [1:0]        wr_sel;
    wire [2:0]        ev_vec;
    wire [2:0]        lane_vec;
    wire [2:0]        wbit_vec;
    wire [2:0]        clr_vec;
    wire [2:0]        set_vec;
    wire              flags_write;
    wire              allow_set;
    wire              dev_reset;
    wire              aw_take;
    wire              w_take;
    wire              b_done;
    wire              ar_take;
    wire              r_done;

    assign dev_reset = !aresetn || self_reset;

    // Channel handshakes, one item per valid and ready edge
    assign aw_take = awvalid && awready;
    assign w_take  = wvalid && wready;
    assign b_done  = bvalid && bready;
    assign ar_take = arvalid && arready;
    assign r_done  = rvalid && rready;

    // Write commits once both address and data are held
    assign do_write    = aw_held_r && w_held_r && !bvalid;
    assign wr_sel      = reg_sel(awaddr_r);
    assign flags_write = do_write && (wr_sel == SEL_FLAGS);

    assign ev_vec   = {unsup_pw_ev, ill_resp_ev, ill_req_ev};
    // Strobe lane and written bit of each field
    genvar gi;
    generate
        for (gi = 0; gi < NFIELD; gi = gi + 1) begin : g_field
            assign lane_vec[gi] = lane_on(wstrb_r, field_pos(gi));
            assign wbit_vec[gi] = wdata_r[field_pos(gi)];
        end
    endgenerate

    // Writing zero clears, writing one leaves the flag alone
    assign clr_vec = {3{flags_write}} & lane_vec & ~wbit_vec;

    // Disabled conditions neither set, lock nor report
    assign set_vec = ev_vec & enables_r;

    // While locked, new errors are dropped until every flag is cleared; an error
    // in the cycle that clears the last one still lands, so the capture
    // contents never change under a partial clear
    assign allow_set = !err_locked_r || ((flags_r & ~clr_vec) == 3'h0);

    always @* begin
        flags_nxt = (flags_r & ~clr_vec) |
                    (set_vec & {3{allow_set}});
        enables_nxt = enables_r;
        if (do_write && (wr_sel == SEL_EN)) begin
            // Only the three enable bits are stored
            if (lane_vec[0]) begin
                enables_nxt[0] = wbit_vec[0];
            end
            if (lane_vec[1]) begin
                enables_nxt[1] = wbit_vec[1];
            end
            if (lane_vec[2]) begin
                enables_nxt[2] = wbit_vec[2];
            end
        end
    end

    // Detect flags
    always @(posedge aclk) begin
        if (dev_reset) begin
            flags_r <= `FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Enables
    always @(posedge aclk) begin
        if (dev_reset) begin
            enables_r <= `ENABLES_RST;
        end else begin
            enables_r <= enables_nxt;
        end
    end

    // Lock level and capture strobe
    always @(posedge aclk) begin
        if (dev_reset) begin
            err_locked_r   <= 1'b0;
            capture_load_r <= 1'b0;
        end else begin
            err_locked_r   <= |flags_nxt;
            // Capture takes the packet while unlocked or in the cycle that clears the last flag
            capture_load_r <= |(set_vec & {3{allow_set}});
        end
    end

    // Write address, held until its response is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            aw_held_r <= 1'b0;
            awaddr_r  <= {ADDR_W{1'b0}};
        end else if (aw_take) begin
            awaddr_r  <= awaddr;
            aw_held_r <= 1'b1;
            awready   <= 1'b0;
        end else if (b_done) begin
            aw_held_r <= 1'b0;
            awready   <= 1'b1;
        end
    end

    // Write data, taken before or after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            wready   <= 1'b1;
            w_held_r <= 1'b0;
            wdata_r  <= 32'h00000000;
            wstrb_r  <= 4'h0;
        end else if (w_take) begin
            wdata_r  <= wdata;
            wstrb_r  <= wstrb;
            w_held_r <= 1'b1;
            wready   <= 1'b0;
        end else if (b_done) begin
            w_held_r <= 1'b0;
            wready   <= 1'b1;
        end
    end

    // Write response once both halves are in
    always @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            // Header is read-only but mapped, so writes are harmless
            if (wr_sel == SEL_NONE) begin
                bresp <= `RESP_SLVERR;
            end else begin
                bresp <= `RESP_OKAY;
            end
        end else if (b_done) begin
            bvalid <= 1'b0;
        end
    end

    // Read data for a decoded register
    reg [31:0] rd_word;
    reg [1:0]  rd_sel;

    always @* begin
        rd_sel  = reg_sel(araddr);
        rd_word = 32'h00000000;
        if (rd_sel == SEL_HDR) begin
            rd_word = {`NEXT_PTR_VAL, `FEATURE_ID_VAL};
        end else if (rd_sel == SEL_FLAGS) begin
            rd_word = place3(flags_r);
        end else if (rd_sel == SEL_EN) begin
            rd_word = place3(enables_r);
        end
    end

    // Read address: one read outstanding
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
        end else if (ar_take) begin
            arready <= 1'b0;
        end else if (r_done) begin
            arready <= 1'b1;
        end
    end

    // Read data, answered one edge after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= `RESP_OKAY;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            if (rd_sel == SEL_NONE) begin
                rresp <= `RESP_SLVERR;
            end else begin
                rresp <= `RESP_OKAY;
            end
        end else if (r_done) begin
            rvalid <= 1'b0;
        end
    end

endmodule // logical_transport_error_detect

/* File: tb/lte_err_chk.sv */
// Port assertions for the logical/transport error detect block
module lte_err_chk #(
    parameter ADDR_W = 16
) (
    // Clock and resets
    input wire              aclk,
    input wire              aresetn,
    input wire              self_reset,
    // Register bus
    input wire              awvalid,
    input wire              awready,
    input wire              wvalid,
    input wire              wready,
    input wire              bvalid,
    input wire [ADDR_W-1:0] araddr,
    input wire              arvalid,
    input wire              arready,
    input wire [31:0]       rdata,
    input wire [1:0]        rresp,
    input wire              rvalid,
    input wire              rready,
    // Packet strobe and lock
    input wire              pkt_valid,
    input wire [3:0]        pkt_ftype,
    input wire [7:0]        pkt_hop,
    input wire              capture_load_r,
    input wire              err_locked_r
);
    timeunit 1ns;
    timeprecision 1ps;
    wire rd_go = arvalid && arready;
    wire wr_go = awvalid && awready && wvalid && wready;
    wire unm   = !(araddr inside {16'h1000, 16'h1008, 16'h100C});
    wire ev    = pkt_valid && pkt_ftype == 4'h8 && pkt_hop == 8'h00;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_hdr; rd_go && araddr == 16'h1000 |=> rdata == 32'h7; endproperty
    a_hdr: assert property (p_hdr) else $error("header");
    property p_unm; rd_go && unm |=> rresp == 2'h2 && rdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_rd; rd_go |=> rvalid && !arready; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_wr; wr_go |-> ##2 bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write answer late");
    property p_rdone; rvalid && rready |=> !rvalid; endproperty
    a_rdone: assert property (p_rdone) else $error("read data held");
    // Lock may only rise two edges after a hop-zero maintenance header
    property p_lock; $rose(err_locked_r) |-> $past(ev, 2); endproperty
    a_lock: assert property (p_lock) else $error("bad lock");
    property p_cap; capture_load_r |-> err_locked_r ##1 !capture_load_r; endproperty
    a_cap: assert property (p_cap) else $error("capture pulse");
    property p_self; self_reset |=> !err_locked_r && !capture_load_r; endproperty
    a_self: assert property (p_self) else $error("self reset");
    c_cap: cover property (capture_load_r);
    c_unm: cover property (rd_go && unm);
    c_self: cover property (self_reset && err_locked_r);
endmodule // lte_err_chk

bind logical_transport_error_detect lte_err_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

/* File: tb/maint_src.sv */
// Behavioural source of maintenance packet headers
module maint_src (
    // Clock
    input  wire        aclk,
    // Header strobe towards the block
    output logic       pkt_valid,
    output logic [3:0] pkt_ftype,
    output logic [3:0] pkt_ttype,
    output logic [1:0] pkt_tt,
    output logic [7:0] pkt_hop
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pkt_valid = 1'b0;
        {pkt_ftype, pkt_ttype, pkt_tt, pkt_hop} = 18'h0;
    end
    // Fields show inverted junk between strobes, never a stale header
    task automatic send(input [3:0] f, t, input [1:0] c, input [7:0] h);
        @(posedge aclk);
        pkt_valid <= 1'b1;
        {pkt_ftype, pkt_ttype, pkt_tt, pkt_hop} <= {f, t, c, h};
        @(posedge aclk);
        pkt_valid <= 1'b0;
        {pkt_ftype, pkt_ttype, pkt_tt, pkt_hop} <= ~{f, t, c, h};
    endtask
endmodule // maint_src

/* File: tb/logical_transport_error_detect_tb.sv */
// Self-checking bench for the error detect register block
module logical_transport_error_detect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] R  = 32'h0800_0000;
    localparam logic [31:0] S  = 32'h0080_0000;
    localparam logic [31:0] P  = 32'h0040_0000;
    localparam logic [15:0] HD = 16'h1000;
    localparam logic [15:0] FL = 16'h1008;
    localparam logic [15:0] EN = 16'h100C;
    logic        aclk, aresetn, self_reset;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [2:0]  awprot, arprot;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         pkt_valid, capture_load_r, err_locked_r;
    wire  [1:0]  bresp, rresp, pkt_tt;
    wire  [31:0] rdata;
    wire  [3:0]  pkt_ftype, pkt_ttype;
    wire  [7:0]  pkt_hop;
    int          n_fail, samples_checked, n_cap, c;

    logical_transport_error_detect dut (.*);
    maint_src src (.*);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) if (capture_load_r === 1'b1) n_cap++;

    task automatic chk(input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic finish_test;
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One AXI4-Lite access; checks response and, for reads, data
    task automatic xfer(input bit w, input [15:0] a, input [31:0] d,
                        input [1:0] er);
        bit          done;
        logic [31:0] v;
        logic [1:0]  r;
        done = 1'b0;
        if (w) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (arvalid && arready) arvalid <= 1'b0;
            if (bready && bvalid) begin
                bready <= 1'b0;
                r = bresp;
                done = 1'b1;
            end
            if (rready && rvalid) begin
                rready <= 1'b0;
                {v, r} = {rdata, rresp};
                done = 1'b1;
            end
        end
        if (!done) begin
            n_fail++;
            finish_test();
        end
        chk({30'h0, r}, {30'h0, er});
        if (!w) chk(v, d);
        @(posedge aclk);
    endtask
    // Send one header, check lock and flags, then clear by writing zero
    task automatic one(input [3:0] f, t, input [1:0] k, input [7:0] h,
                       input [31:0] e);
        src.send(f, t, k, h);
        repeat (3) @(posedge aclk);
        chk({31'h0, err_locked_r}, {31'h0, e != 32'h0});
        xfer(1'b0, FL, e, 2'h0);
        xfer(1'b1, FL, 32'h0, 2'h0);
    endtask

    task automatic t_regs;
        xfer(1'b0, HD, 32'h7, 2'h0);
        xfer(1'b0, FL, 32'h0, 2'h0);
        xfer(1'b0, EN, 32'h0, 2'h0);
        xfer(1'b1, HD, '1, 2'h0);
        xfer(1'b0, HD, 32'h7, 2'h0);
        xfer(1'b1, EN, '1, 2'h0);
        xfer(1'b0, EN, R | S | P, 2'h0);
        xfer(1'b1, FL, '1, 2'h0);
        xfer(1'b0, FL, 32'h0, 2'h0);
        xfer(1'b0, 16'h1004, 32'h0, 2'h2);
        xfer(1'b1, 16'h1010, '1, 2'h2);
        xfer(1'b0, EN, R | S | P, 2'h0);
    endtask
    task automatic t_pkt;
        c = n_cap;
        one(4'h8, 4'h5, 2'h0, 8'h00, R);
        one(4'h8, 4'hF, 2'h1, 8'h00, R);
        one(4'h8, 4'h0, 2'h2, 8'h00, R);
        one(4'h8, 4'h1, 2'h3, 8'h00, R);
        one(4'h8, 4'h1, 2'h1, 8'h00, 0);
        one(4'h8, 4'h2, 2'h0, 8'h00, S);
        one(4'h8, 4'h3, 2'h0, 8'h00, S);
        one(4'h8, 4'h4, 2'h0, 8'h00, P);
        one(4'h8, 4'h3, 2'h0, 8'h01, 0);
        one(4'h8, 4'h5, 2'h2, 8'hFF, 0);
        one(4'h5, 4'h4, 2'h0, 8'h00, 0);
        chk(n_cap - c, 7);
    endtask
    task automatic t_lock;
        xfer(1'b1, EN, S, 2'h0);
        one(4'h8, 4'h6, 2'h0, 8'h00, 0);
        c = n_cap;
        src.send(4'h8, 4'h2, 2'h0, 8'h00);
        src.send(4'h8, 4'h4, 2'h0, 8'h00);
        xfer(1'b1, EN, S | P, 2'h0);
        src.send(4'h8, 4'h4, 2'h0, 8'h00);
        repeat (3) @(posedge aclk);
        xfer(1'b0, FL, S, 2'h0);
        chk(n_cap - c, 1);
        xfer(1'b1, FL, 32'h0, 2'h0);
        one(4'h8, 4'h4, 2'h0, 8'h00, P);
    endtask
    task automatic t_self;
        xfer(1'b1, EN, R, 2'h0);
        src.send(4'h8, 4'h9, 2'h0, 8'h00);
        repeat (3) @(posedge aclk);
        chk({31'h0, err_locked_r}, 32'h1);
        self_reset <= 1'b1;
        @(posedge aclk);
        self_reset <= 1'b0;
        xfer(1'b0, FL, 32'h0, 2'h0);
        xfer(1'b0, EN, 32'h0, 2'h0);
        chk({31'h0, err_locked_r}, 32'h0);
        xfer(1'b1, EN, R | S, 2'h0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        xfer(1'b0, EN, 32'h0, 2'h0);
    endtask

    initial begin
        aresetn = 1'b0;
        self_reset = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = 64'h0;
        {awprot, arprot} = 6'h0;
        wstrb = 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_pkt();
        t_lock();
        t_self();
        finish_test();
    end
endmodule // logical_transport_error_detect_tb
